// *** core/lps_pkg.sv ***
package lps_pkg;
  localparam int CLK_MHZ = 250;
  localparam int SS_US_PER_NF = 200;
  localparam int SS_CYC_PER_NF = SS_US_PER_NF * CLK_MHZ;
  localparam int FAULT_MS = 55;
  localparam int FAULT_CYC = FAULT_MS * 1000 * CLK_MHZ;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0004;
  localparam logic [7:0] SS_CAP_RST = 8'h0a;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int NSYNC = 13;
  localparam int SI_SUPPLY_LOW_LOCKOUT = 0;
  localparam int SI_EN = 1;
  localparam int SI_GDONE = 2;
  localparam int SI_BUF_OK = 3;
  localparam int SI_LDO_OK = 4;
  localparam int SI_DLY = 5;
  localparam int SI_OFLT = 6;
  localparam int SI_OV = 7;
  localparam int SI_HOT = 8;
  localparam int SI_VOLTAGE_DETECT_IN = 9;
  localparam int SI_ALOW = 10;
  localparam int SI_FLK = 11;
  localparam int SI_HVS = 12;
  typedef enum logic [2:0] {ST_OFF, ST_GATE, ST_SOFT, ST_DELAY, ST_RUN, ST_HOT} lps_state_t;
  typedef struct packed {
    logic [20:0] rsvd;
    logic alarm;
    logic gsup_dis_on;
    logic gsup_high_on;
    logic ldo_en;
    logic buf_en;
    logic boost_en;
    logic gate_drive;
    logic fault_latch;
    lps_state_t st;
  } lps_status_t;
endpackage

// *** core/lps_sync.sv ***
`timescale 1ns/10ps
module lps_sync import lps_pkg::*; #(
  parameter int W = NSYNC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // The first stage is read only by the second stage.
  logic [W-1:0] meta_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** core/lps_top.sv ***
`timescale 1ns/10ps
module lps_top import lps_pkg::*; #(
  parameter int SS_CYC = SS_CYC_PER_NF,
  parameter int FLT_CYC = FAULT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_low_lockout,
  input wire logic enable_in,
  input wire logic gate_done_in,
  input wire logic buffer_supply_rail_ok,
  input wire logic ldo_rail_ok,
  input wire logic switch_delay_node_above,
  input wire logic output_fault_in,
  input wire logic overvoltage_guard,
  input wire logic overtemp_in,
  input wire logic voltage_detect_in,
  input wire logic alarm_supply_low,
  input wire logic flicker_select_in,
  input wire logic stress_mode_enable,
  output logic boost_en,
  output logic boost_switch_en,
  output logic soft_start_run,
  output logic ldo_en,
  output logic buffer_en,
  output logic gate_drive,
  output logic gsup_high_on,
  output logic gsup_dis_on,
  output logic delay_discharge,
  output logic delay_charge,
  output logic stress_switch_out_o,
  output logic stress_switch_out_oe,
  output logic alarm_out_n_o,
  output logic alarm_out_n_oe
);
  typedef struct packed {
    lps_state_t st;
    logic fault_latch;
    logic [23:0] tmr;
    logic [15:0] pre;
    logic [7:0] nf;
    logic [7:0] ss_cap;
    logic boost_en;
    logic boost_sw;
    logic ss_run;
    logic ldo_en;
    logic buf_en;
    logic gate_drive;
    logic gsup_high_on;
    logic gsup_dis_on;
    logic dly_dis;
    logic dly_chg;
    logic stress_oe;
    logic alarm_oe;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [31:0] waddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } lps_regs_t;

  lps_regs_t q, d;
  logic [NSYNC-1:0] s;
  logic s_supply_low_lockout, s_en, s_hot, alarm, sw_act;
  lps_status_t stat;

  function automatic logic hit(input logic [31:0] a);
    hit = (a == ADDR_CTRL) || (a == ADDR_STAT);
  endfunction

  function automatic logic powered(input lps_state_t st);
    powered = (st == ST_SOFT) || (st == ST_DELAY) || (st == ST_RUN);
  endfunction

  lps_sync #(.W(NSYNC)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({stress_mode_enable, flicker_select_in, alarm_supply_low, voltage_detect_in, overtemp_in,
               overvoltage_guard, output_fault_in, switch_delay_node_above, ldo_rail_ok,
               buffer_supply_rail_ok, gate_done_in, enable_in, supply_low_lockout}),
    .sync_out(s)
  );

  assign s_supply_low_lockout = s[SI_SUPPLY_LOW_LOCKOUT];
  assign s_en = s[SI_EN];
  assign s_hot = s[SI_HOT];

  always_comb begin
    d = q;
    stat = '0;
    alarm = 1'b0;
    sw_act = 1'b0;
    case (q.st)
      ST_OFF: begin
        if (!s_supply_low_lockout && s_en && !q.fault_latch) begin
          d.st = ST_GATE;
        end
      end
      ST_GATE: begin
        if (s[SI_GDONE]) begin
          d.st = ST_SOFT;
          d.pre = '0;
          d.nf = '0;
        end
      end
      ST_SOFT: begin
        // The ramp is paced by programmed capacitance, so no pin is needed for it.
        if (q.nf >= q.ss_cap) begin
          d.st = ST_DELAY;
        end else if (q.pre == 16'(SS_CYC - 1)) begin
          d.pre = '0;
          d.nf = q.nf + 8'h01;
        end else begin
          d.pre = q.pre + 16'h0001;
        end
      end
      ST_DELAY: begin
        if (s[SI_DLY]) begin
          d.st = ST_RUN;
          d.tmr = '0;
        end
      end
      ST_RUN: begin
        if (s[SI_OFLT]) begin
          d.tmr = q.tmr + 24'h00_0001;
          if (q.tmr == 24'(FLT_CYC - 1)) begin
            d.st = ST_OFF;
          end
        end else begin
          d.tmr = '0;
        end
      end
      ST_HOT: begin
        // Cooling hysteresis lives in the comparator, so release is immediate.
        if (!s_hot) begin
          d.st = ST_OFF;
        end
      end
      default: d.st = ST_OFF;
    endcase
    // A set arriving together with a supply lockout still wins.
    d.fault_latch = (q.st == ST_RUN && s[SI_OFLT] && q.tmr == 24'(FLT_CYC - 1))
                    || (q.fault_latch && !s_supply_low_lockout);
    if (s_supply_low_lockout || !s_en) begin
      d.st = ST_OFF;
    end
    if (s_hot) begin
      d.st = ST_HOT;
    end
    d.gate_drive = (d.st == ST_OFF) || (d.st == ST_HOT);
    d.boost_en = powered(d.st);
    d.boost_sw = d.boost_en && !s[SI_OV];
    d.ss_run = (d.st == ST_SOFT);
    d.buf_en = d.boost_en && s[SI_BUF_OK];
    d.ldo_en = d.boost_en && s[SI_LDO_OK];
    d.dly_chg = (d.st == ST_DELAY) || (d.st == ST_RUN);
    d.dly_dis = !d.dly_chg;
    sw_act = (d.st == ST_RUN);
    alarm = s_supply_low_lockout || !s[SI_VOLTAGE_DETECT_IN];
    d.alarm_oe = alarm && !s[SI_ALOW];
    d.gsup_high_on = alarm || (sw_act && s[SI_FLK]);
    d.gsup_dis_on = !alarm && sw_act && !s[SI_FLK];
    d.stress_oe = s[SI_HVS];
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (q.awready && s_axi_awvalid) begin
      d.aw_got = 1'b1;
      d.waddr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (d.aw_got && d.w_got && !d.bvalid) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = hit(d.waddr) ? RESP_OKAY : RESP_DECERR;
      if (d.waddr == ADDR_CTRL && d.wstrb0) begin
        d.ss_cap = d.wdata;
      end
    end
    d.awready = !d.aw_got && !d.bvalid;
    d.wready = !d.w_got && !d.bvalid;
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (q.arready && s_axi_arvalid) begin
      stat.st = q.st;
      stat.fault_latch = q.fault_latch;
      stat.gate_drive = q.gate_drive;
      stat.boost_en = q.boost_en;
      stat.buf_en = q.buf_en;
      stat.ldo_en = q.ldo_en;
      stat.gsup_high_on = q.gsup_high_on;
      stat.gsup_dis_on = q.gsup_dis_on;
      stat.alarm = q.alarm_oe;
      d.rvalid = 1'b1;
      d.rresp = hit(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
      d.rdata = (s_axi_araddr == ADDR_CTRL) ? {24'h00_0000, q.ss_cap} :
                (s_axi_araddr == ADDR_STAT) ? stat : 32'h0000_0000;
    end
    d.arready = !d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.st <= ST_OFF;
      q.gate_drive <= 1'b1;
      q.dly_dis <= 1'b1;
      q.ss_cap <= SS_CAP_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bresp = q.bresp;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_arready = q.arready;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign s_axi_rvalid = q.rvalid;
  assign boost_en = q.boost_en;
  assign boost_switch_en = q.boost_sw;
  assign soft_start_run = q.ss_run;
  assign ldo_en = q.ldo_en;
  assign buffer_en = q.buf_en;
  assign gate_drive = q.gate_drive;
  assign gsup_high_on = q.gsup_high_on;
  assign gsup_dis_on = q.gsup_dis_on;
  assign delay_discharge = q.dly_dis;
  assign delay_charge = q.dly_chg;
  assign stress_switch_out_o = q.fault_latch & 1'b0;
  assign stress_switch_out_oe = q.stress_oe;
  assign alarm_out_n_o = q.fault_latch & 1'b0;
  assign alarm_out_n_oe = q.alarm_oe;

  logic [31:0] ss_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ss_cnt <= '0;
    end else begin
      ss_cnt <= (q.st == ST_SOFT) ? ss_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_start_cond: assert property ((q.st == ST_OFF && d.st == ST_GATE) |-> (!s_supply_low_lockout && s_en))
    else $error("startup without supply or enable");
  chk_lockout_off: assert property (s_supply_low_lockout |=> (!q.boost_en && !q.ldo_en && !q.buf_en && q.gate_drive))
    else $error("lockout left an output on");
  chk_latch_gate: assert property (q.fault_latch |-> q.gate_drive)
    else $error("gate low with fault latched");
  chk_soft_gate: assert property ((q.st == ST_SOFT && $past(q.st) == ST_GATE) |-> $past(s[SI_GDONE]))
    else $error("soft-start before gate done");
  chk_buf_rail: assert property (q.buf_en |-> $past(s[SI_BUF_OK]) && q.boost_en)
    else $error("buffer enabled without its rail");
  chk_ss_length: assert property ((q.st == ST_SOFT && d.st == ST_DELAY && $stable(q.ss_cap))
    |-> ss_cnt == q.ss_cap * SS_CYC)
    else $error("soft-start length wrong");
  chk_delay_done: assert property ((q.st == ST_RUN && $past(q.st) == ST_DELAY) |-> $past(s[SI_DLY]))
    else $error("switch block before delay");
  chk_delay_hold: assert property ((s_supply_low_lockout || !s_en) |=> (q.dly_dis && !q.dly_chg && !q.gsup_dis_on))
    else $error("delay node not discharged");
  chk_flicker_sel: assert property ((d.st == ST_RUN && !alarm) |-> ##1
    (q.gsup_high_on == $past(s[SI_FLK]) && q.gsup_dis_on == !$past(s[SI_FLK])))
    else $error("gate-supply switch mismatch");
  chk_preactive: assert property ((d.st != ST_RUN && !alarm) |=> (!q.gsup_high_on && !q.gsup_dis_on))
    else $error("switch on before activation");
  chk_fault_time: assert property ($rose(q.fault_latch) |-> $past(q.tmr) == 24'(FLT_CYC - 1))
    else $error("fault latch timing wrong");
  chk_latch_clear: assert property ($fell(q.fault_latch) |-> $past(s_supply_low_lockout))
    else $error("fault latch cleared without lockout");
  chk_ov_stop: assert property (s[SI_OV] |=> !q.boost_sw)
    else $error("switching during overvoltage");
  chk_hot_off: assert property (s_hot |=> (q.gate_drive && !q.boost_en && q.st == ST_HOT))
    else $error("overtemperature did not shut down");
  chk_stress_sw: assert property (q.stress_oe == $past(s[SI_HVS]))
    else $error("stress switch mismatch");
  chk_alarm_out: assert property ((alarm && !s[SI_ALOW]) |=> (q.alarm_oe && q.gsup_high_on))
    else $error("alarm not asserted");

  cov_reach_run: cover property (q.st == ST_DELAY ##1 q.st == ST_RUN);
  cov_fault_set: cover property ($rose(q.fault_latch));
  cov_hot_restart: cover property (q.st == ST_HOT ##1 q.st == ST_OFF);
  cov_axi_write: cover property (q.bvalid && s_axi_bready && q.bresp == RESP_OKAY);
endmodule

// *** tb/lps_analog_model.sv ***
`timescale 1ns/10ps
module lps_analog_model (
  input wire logic aclk,
  input wire logic gate_drive,
  input wire logic boost_en,
  input wire logic delay_charge,
  input wire logic delay_discharge,
  output logic gate_done_in,
  output logic buffer_supply_rail_ok,
  output logic ldo_rail_ok,
  output logic switch_delay_node_above
);
  // Analog ramps are cycle counts; they saturate so a long run cannot wrap.
  logic [4:0] gate_q = 5'h00;
  logic [4:0] rail_q = 5'h00;
  logic [4:0] dly_q = 5'h00;
  always @(posedge aclk) begin
    gate_q <= gate_drive ? 5'h00 : gate_q + {4'h0, gate_q != 5'h1f};
    rail_q <= !boost_en ? 5'h00 : rail_q + {4'h0, rail_q != 5'h1f};
    dly_q <= delay_discharge ? 5'h00 : dly_q + {4'h0, delay_charge && dly_q != 5'h1f};
  end
  assign gate_done_in = gate_q > 5'h0c;
  assign buffer_supply_rail_ok = rail_q > 5'h04;
  assign ldo_rail_ok = rail_q > 5'h06;
  assign switch_delay_node_above = dly_q > 5'h0b;
endmodule

// *** tb/lps_top_bench.sv ***
`timescale 1ns/10ps
module lps_top_bench import lps_pkg::*; ;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic supply_low_lockout = 1'b1, enable_in = 1'b0, output_fault_in = 1'b0;
  logic overvoltage_guard = 1'b0, overtemp_in = 1'b0, voltage_detect_in = 1'b1;
  logic alarm_supply_low = 1'b0, flicker_select_in = 1'b1, stress_mode_enable = 1'b0;
  logic gate_done_in, buffer_supply_rail_ok, ldo_rail_ok, switch_delay_node_above;
  logic boost_en, boost_switch_en, soft_start_run, ldo_en, buffer_en, gate_drive;
  logic gsup_high_on, gsup_dis_on, delay_discharge, delay_charge;
  logic stress_switch_out_o, stress_switch_out_oe, alarm_out_n_o, alarm_out_n_oe;
  int n_mismatch = 0;
  int checks_done = 0;

  lps_top #(.SS_CYC(4), .FLT_CYC(16)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_low_lockout, .enable_in, .gate_done_in,
    .buffer_supply_rail_ok, .ldo_rail_ok, .switch_delay_node_above, .output_fault_in,
    .overvoltage_guard, .overtemp_in, .voltage_detect_in, .alarm_supply_low, .flicker_select_in,
    .stress_mode_enable, .boost_en, .boost_switch_en, .soft_start_run, .ldo_en, .buffer_en,
    .gate_drive, .gsup_high_on, .gsup_dis_on, .delay_discharge, .delay_charge,
    .stress_switch_out_o, .stress_switch_out_oe, .alarm_out_n_o, .alarm_out_n_oe);

  lps_analog_model far (.aclk, .gate_drive, .boost_en, .delay_charge, .delay_discharge,
    .gate_done_in, .buffer_supply_rail_ok, .ldo_rail_ok, .switch_delay_node_above);

  always #2 aclk = ~aclk;

  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    $display("CHECK FAILED %s expected done seen timeout", nm);
    n_mismatch++;
    give_verdict();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) hang("write");
    chk("bresp", er, s_axi_bresp);
    @(posedge aclk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] q);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    q = s_axi_rdata;
    if (n >= 50) hang("read");
    chk("rresp", er, s_axi_rresp);
    @(posedge aclk);
  endtask

  task automatic wait_st(input logic [2:0] s);
    logic [31:0] q;
    int n = 0;
    do begin
      rd(ADDR_STAT, RESP_OKAY, q);
      n++;
    end while (q[2:0] !== s && n < 200);
    if (n >= 200) hang("state");
  endtask

  task automatic t_reset();
    logic [31:0] q;
    chk("gate_drive", 1, gate_drive);
    chk("delay_discharge", 1, delay_discharge);
    rd(ADDR_CTRL, RESP_OKAY, q);
    chk("ctrl", {24'h00_0000, SS_CAP_RST}, q);
    rd(32'h0000_0010, RESP_DECERR, q);
    chk("unmapped", 0, q);
    wr(32'h0000_0010, 32'h0000_00ff, RESP_DECERR);
    wr(ADDR_CTRL, 32'h0000_0008, RESP_OKAY);
    // A write without byte 0 enabled must leave the capacitance alone.
    s_axi_wstrb <= 4'he;
    wr(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(ADDR_CTRL, RESP_OKAY, q);
    chk("ctrl", 32'h0000_0008, q);
    enable_in <= 1'b1;
    cyc(8);
    rd(ADDR_STAT, RESP_OKAY, q);
    chk("state", 0, q[2:0]);
  endtask

  task automatic t_start();
    int k = 0;
    supply_low_lockout <= 1'b0;
    wait_st(3'h1);
    chk("boost_en", 0, boost_en);
    while (soft_start_run !== 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 100) hang("soft start begin");
    chk("gsup_high_on", 0, gsup_high_on);
    chk("gsup_dis_on", 0, gsup_dis_on);
    k = 0;
    while (soft_start_run === 1'b1 && k < 100) begin
      @(posedge aclk);
      k++;
    end
    if (k >= 100) hang("soft start end");
    chk("ss_len", 8 * 4 + 1, k);
    cyc(1);
    chk("delay_charge", 1, delay_charge);
    chk("gsup_high_on", 0, gsup_high_on);
    wait_st(3'h4);
    chk("gate_drive", 0, gate_drive);
    chk("buffer_en", 1, buffer_en);
    chk("ldo_en", 1, ldo_en);
    chk("gsup_high_on", 1, gsup_high_on);
    chk("gsup_dis_on", 0, gsup_dis_on);
    flicker_select_in <= 1'b0;
    cyc(4);
    chk("gsup_high_on", 0, gsup_high_on);
    chk("gsup_dis_on", 1, gsup_dis_on);
  endtask

  task automatic t_pins();
    for (int v = 0; v < 2; v++) begin
      overvoltage_guard <= v[0];
      stress_mode_enable <= v[0];
      cyc(4);
      chk("boost_switch_en", !v[0], boost_switch_en);
      chk("boost_en", 1, boost_en);
      chk("stress_oe", v[0], stress_switch_out_oe);
      chk("stress_o", 0, stress_switch_out_o);
    end
    overvoltage_guard <= 1'b0;
    stress_mode_enable <= 1'b0;
    voltage_detect_in <= 1'b0;
    cyc(4);
    chk("alarm_oe", 1, alarm_out_n_oe);
    chk("alarm_o", 0, alarm_out_n_o);
    chk("gsup_high_on", 1, gsup_high_on);
    alarm_supply_low <= 1'b1;
    cyc(4);
    chk("alarm_oe", 0, alarm_out_n_oe);
    alarm_supply_low <= 1'b0;
    voltage_detect_in <= 1'b1;
    overtemp_in <= 1'b1;
    cyc(4);
    chk("gate_drive", 1, gate_drive);
    chk("boost_en", 0, boost_en);
    overtemp_in <= 1'b0;
    wait_st(3'h4);
  endtask

  task automatic t_fault();
    logic [31:0] q;
    // A glitch shorter than the timer must not latch.
    output_fault_in <= 1'b1;
    cyc(10);
    output_fault_in <= 1'b0;
    cyc(4);
    chk("gate_drive", 0, gate_drive);
    output_fault_in <= 1'b1;
    cyc(24);
    rd(ADDR_STAT, RESP_OKAY, q);
    chk("fault_latch", 1, q[3]);
    chk("gate_drive", 1, gate_drive);
    chk("boost_en", 0, boost_en);
    output_fault_in <= 1'b0;
    enable_in <= 1'b0;
    cyc(4);
    chk("delay_discharge", 1, delay_discharge);
    chk("gsup_dis_on", 0, gsup_dis_on);
    enable_in <= 1'b1;
    cyc(10);
    chk("gate_drive", 1, gate_drive);
    supply_low_lockout <= 1'b1;
    cyc(4);
    chk("buffer_en", 0, buffer_en);
    chk("ldo_en", 0, ldo_en);
    chk("gsup_dis_on", 0, gsup_dis_on);
    chk("alarm_oe", 1, alarm_out_n_oe);
    supply_low_lockout <= 1'b0;
    wait_st(3'h4);
    // Lockout from a running state, where boost, buffer, LDO and gsup_dis_on are on and gate_drive is off to begin with.
    supply_low_lockout <= 1'b1;
    cyc(4);
    chk("boost_en", 0, boost_en);
    chk("gate_drive", 1, gate_drive);
    chk("buffer_en", 0, buffer_en);
    chk("ldo_en", 0, ldo_en);
    chk("gsup_dis_on", 0, gsup_dis_on);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_start();
    t_pins();
    t_fault();
    give_verdict();
  end
endmodule
